// ---- otc_top.sv ----
`timescale 1ns/1ns
// Function
// - The fast oscillator trim is 8 bits, low code slowest, high code fastest, 0x90 at reset.
// - Writing one to the calibration trigger bit starts one calibration run.
// - With the 1 MHz low oscillator, fast cycles are counted over 128 low cycles.
// - With the 32 kHz low oscillator, fast cycles are counted over 32 low cycles.
// - At the end of each run the count is loaded into the calibration tally.
// - The tally is a 15-bit read-only field of the last run, zero at reset.
// - The 1 MHz oscillator trim is 10 bits, low code slowest, high code fastest, 0x2B2 at reset.
// - Once software sets the arm bit, the next rising edge of the stamp pin captures the count.
// - The arm bit clears itself when a capture has happened.
// - The 6-bit 32 kHz trim runs from fastest at zero to slowest at all ones, 0x12 at reset.
// - The low 16 bits of the captured count read from one read-only register.
// - The high 16 bits of the captured count read from a second read-only register.
// - A read-only 16-bit field gives the count left to the next slot at capture.
module otc_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial register port, already deserialised
  input wire otc_pkg::otc_reg_req_t reg_req,
  output logic [otc_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Oscillator monitor ticks and selection
  input wire logic hf_osc_tick,
  input wire logic lf_osc_tick,
  input wire logic lf_slow_sel,
  // Time stamp source
  input wire logic [otc_pkg::GPIO_W-1:0] gpio_in,
  input wire logic [otc_pkg::PIN_SEL_W-1:0] stamp_pin_sel,
  input wire logic [2*otc_pkg::DATA_W-1:0] free_count,
  input wire logic [otc_pkg::DATA_W-1:0] slot_remaining,
  // Oscillator trims
  output logic [otc_pkg::HF_TRIM_W-1:0] hf_osc_trim,
  output logic [otc_pkg::FAST_LF_TRIM_W-1:0] fast_lf_osc_trim,
  output logic [otc_pkg::SLOW_TRIM_W-1:0] slow_osc_trim,
  // Status
  output logic hf_cal_trigger,
  output logic stamp_arm,
  output logic stamp_taken
);
  import otc_pkg::*;

  logic wr_hf_trim;
  logic wr_hf_cal;
  logic wr_fast_lf;
  logic wr_slow_ctrl;
  logic cal_start;
  logic cal_done;
  logic [TALLY_W-1:0] hf_cal_tally;
  logic stamp_pin;
  logic stamp_captured;
  otc_stamp_snap_t stamp_snap;
  logic [DATA_W-1:0] rdata_next;

  // Write decode; read-only addresses and reserved bits ignore writes
  assign wr_hf_trim = reg_req.wr && otc_hit(reg_req.addr, ADDR_HF_TRIM);
  assign wr_hf_cal = reg_req.wr && otc_hit(reg_req.addr, ADDR_HF_CAL);
  assign wr_fast_lf = reg_req.wr && otc_hit(reg_req.addr, ADDR_FAST_LF_TRIM);
  assign wr_slow_ctrl = reg_req.wr && otc_hit(reg_req.addr, ADDR_SLOW_CTRL);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hf_osc_trim <= HF_TRIM_RST;
    end else if (wr_hf_trim) begin
      hf_osc_trim <= reg_req.wdata[HF_TRIM_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fast_lf_osc_trim <= FAST_LF_TRIM_RST;
    end else if (wr_fast_lf) begin
      fast_lf_osc_trim <= reg_req.wdata[FAST_LF_TRIM_W-1:0];
    end
  end

  // Code goes down as frequency goes up; trim is passed through untouched
  always_ff @(posedge core_clk) begin
    if (rst) begin
      slow_osc_trim <= SLOW_TRIM_RST;
    end else if (wr_slow_ctrl) begin
      slow_osc_trim <= reg_req.wdata[SLOW_TRIM_W-1:0];
    end
  end

  // A start is accepted when idle or in the very cycle a run completes,
  // so a trigger landing on the completion is not lost. A run cannot be
  // aborted: writing zero while busy has no effect.
  assign cal_start = wr_hf_cal && reg_req.wdata[CAL_TRIG_BIT] &&
                     (!hf_cal_trigger || cal_done);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hf_cal_trigger <= 1'b0;
    end else if (cal_start) begin
      hf_cal_trigger <= 1'b1;
    end else if (cal_done) begin
      hf_cal_trigger <= 1'b0;
    end
  end

  otc_cal_counter u_cal (
    .core_clk(core_clk),
    .rst(rst),
    .start(cal_start),
    .slow_lf(lf_slow_sel),
    .hf_tick(hf_osc_tick),
    .lf_tick(lf_osc_tick),
    .done(cal_done),
    .tally(hf_cal_tally)
  );

  // Pin zero after reset unless the selector says otherwise
  assign stamp_pin = gpio_in[stamp_pin_sel];

  // Set by software wins over the self clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stamp_arm <= 1'b0;
    end else if (wr_slow_ctrl) begin
      stamp_arm <= reg_req.wdata[STAMP_ARM_BIT];
    end else if (stamp_captured) begin
      stamp_arm <= 1'b0;
    end
  end

  otc_stamp_capture u_stamp (
    .core_clk(core_clk),
    .rst(rst),
    .armed(stamp_arm),
    .pin_level(stamp_pin),
    .free_count(free_count),
    .slot_remaining(slot_remaining),
    .captured(stamp_captured),
    .snap(stamp_snap)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stamp_taken <= 1'b0;
    end else begin
      stamp_taken <= stamp_captured;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = WORD_ZERO;
    if (otc_hit(reg_req.addr, ADDR_HF_TRIM)) begin
      rdata_next[HF_TRIM_W-1:0] = hf_osc_trim;
    end else if (otc_hit(reg_req.addr, ADDR_HF_CAL)) begin
      rdata_next[CAL_TRIG_BIT] = hf_cal_trigger;
      rdata_next[TALLY_W-1:0] = hf_cal_tally;
    end else if (otc_hit(reg_req.addr, ADDR_FAST_LF_TRIM)) begin
      rdata_next[FAST_LF_TRIM_W-1:0] = fast_lf_osc_trim;
    end else if (otc_hit(reg_req.addr, ADDR_SLOW_CTRL)) begin
      rdata_next[STAMP_ARM_BIT] = stamp_arm;
      rdata_next[SLOW_TRIM_W-1:0] = slow_osc_trim;
    end else if (otc_hit(reg_req.addr, ADDR_STAMP_LOW)) begin
      rdata_next = stamp_snap.count_low;
    end else if (otc_hit(reg_req.addr, ADDR_STAMP_HIGH)) begin
      rdata_next = stamp_snap.count_high;
    end else if (otc_hit(reg_req.addr, ADDR_STAMP_SLOT)) begin
      rdata_next = stamp_snap.slot_remaining;
    end
  end

  // Read data is held until the next read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= WORD_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

endmodule // otc_top

// ---- otc_pkg.sv ----
package otc_pkg;

  // Register port geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_HF_TRIM = 16'h0009;
  localparam logic [ADDR_W-1:0] ADDR_HF_CAL = 16'h000A;
  localparam logic [ADDR_W-1:0] ADDR_FAST_LF_TRIM = 16'h000B;
  localparam logic [ADDR_W-1:0] ADDR_SLOW_CTRL = 16'h000C;
  localparam logic [ADDR_W-1:0] ADDR_STAMP_LOW = 16'h0011;
  localparam logic [ADDR_W-1:0] ADDR_STAMP_HIGH = 16'h0012;
  localparam logic [ADDR_W-1:0] ADDR_STAMP_SLOT = 16'h0013;

  // Field widths and positions
  localparam int HF_TRIM_W = 8;
  localparam int TALLY_W = 15;
  localparam int FAST_LF_TRIM_W = 10;
  localparam int SLOW_TRIM_W = 6;
  localparam int CAL_TRIG_BIT = 15;
  localparam int STAMP_ARM_BIT = 15;
  localparam int PIN_SEL_W = 2;
  localparam int GPIO_W = 4;

  // Values after reset
  localparam logic [HF_TRIM_W-1:0] HF_TRIM_RST = 8'h90;
  localparam logic [FAST_LF_TRIM_W-1:0] FAST_LF_TRIM_RST = 10'h2B2;
  localparam logic [SLOW_TRIM_W-1:0] SLOW_TRIM_RST = 6'h12;
  localparam logic [TALLY_W-1:0] TALLY_RST = 15'h0000;
  localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;

  // Calibration windows in low frequency oscillator cycles
  localparam int WIN_W = 8;
  localparam logic [WIN_W-1:0] CAL_WIN_FAST = 8'h80;
  localparam logic [WIN_W-1:0] CAL_WIN_SLOW = 8'h20;
  localparam logic [WIN_W-1:0] WIN_ONE = 8'h01;
  localparam logic [TALLY_W-1:0] TALLY_MAX = 15'h7FFF;
  localparam logic [TALLY_W-1:0] TALLY_ONE = 15'h0001;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } otc_reg_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] count_high;
    logic [DATA_W-1:0] count_low;
    logic [DATA_W-1:0] slot_remaining;
  } otc_stamp_snap_t;

  // Address match, used by both the write and the read decode
  function automatic logic otc_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] target);
    otc_hit = (addr == target);
  endfunction

endpackage

// ---- otc_cal_counter.sv ----
`timescale 1ns/1ns
module otc_cal_counter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic slow_lf,
  // Oscillator ticks
  input wire logic hf_tick,
  input wire logic lf_tick,
  // Result
  output logic done,
  output logic [otc_pkg::TALLY_W-1:0] tally
);
  import otc_pkg::*;

  typedef enum logic [1:0] {CAL_IDLE, CAL_ALIGN, CAL_COUNT} otc_cal_state_t;

  otc_cal_state_t state_reg;
  logic [WIN_W-1:0] win_reg;
  logic [WIN_W-1:0] lf_count_reg;
  logic [TALLY_W-1:0] hf_count_reg;
  logic [TALLY_W-1:0] hf_count_next;
  logic window_end;

  // Saturate rather than wrap so a fast oscillator never reads as slow
  always_comb begin
    hf_count_next = hf_count_reg;
    if (hf_tick && hf_count_reg != TALLY_MAX) begin
      hf_count_next = hf_count_reg + TALLY_ONE;
    end
  end

  assign window_end = (state_reg == CAL_COUNT) && lf_tick &&
                      (lf_count_reg == win_reg - WIN_ONE);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= CAL_IDLE;
    end else if (start) begin
      state_reg <= CAL_ALIGN;
    end else begin
      unique case (state_reg)
        CAL_IDLE: state_reg <= CAL_IDLE;
        // Window opens on a low frequency edge, not mid-cycle
        CAL_ALIGN: if (lf_tick) begin
          state_reg <= CAL_COUNT;
        end
        CAL_COUNT: if (window_end) begin
          state_reg <= CAL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      win_reg <= CAL_WIN_FAST;
    end else if (start) begin
      win_reg <= slow_lf ? CAL_WIN_SLOW : CAL_WIN_FAST;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lf_count_reg <= '0;
      hf_count_reg <= TALLY_RST;
    end else if (state_reg == CAL_ALIGN) begin
      lf_count_reg <= '0;
      hf_count_reg <= TALLY_RST;
    end else if (state_reg == CAL_COUNT) begin
      hf_count_reg <= hf_count_next;
      if (lf_tick) begin
        lf_count_reg <= lf_count_reg + WIN_ONE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tally <= TALLY_RST;
      done <= 1'b0;
    end else begin
      done <= window_end;
      if (window_end) begin
        tally <= hf_count_next;
      end
    end
  end

endmodule // otc_cal_counter

// ---- otc_stamp_capture.sv ----
`timescale 1ns/1ns
module otc_stamp_capture (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic armed,
  input wire logic pin_level,
  // Live counts
  input wire logic [2*otc_pkg::DATA_W-1:0] free_count,
  input wire logic [otc_pkg::DATA_W-1:0] slot_remaining,
  // Result
  output logic captured,
  output otc_pkg::otc_stamp_snap_t snap
);
  import otc_pkg::*;

  logic pin_prev_reg;
  logic rise;

  // History runs while disarmed so a pin already high at arming is no edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_level;
    end
  end

  assign rise = pin_level && !pin_prev_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      captured <= 1'b0;
      snap <= '0;
    end else begin
      captured <= armed && rise;
      if (armed && rise) begin
        snap.count_low <= free_count[DATA_W-1:0];
        snap.count_high <= free_count[2*DATA_W-1:DATA_W];
        snap.slot_remaining <= slot_remaining;
      end
    end
  end

endmodule // otc_stamp_capture

// ---- otc_monitor.sv ----
`timescale 1ns/1ns
module otc_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire otc_pkg::otc_reg_req_t reg_req,
  input wire logic [otc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  // Oscillators
  input wire logic hf_osc_tick,
  input wire logic lf_osc_tick,
  input wire logic lf_slow_sel,
  // Stamp source
  input wire logic [otc_pkg::GPIO_W-1:0] gpio_in,
  input wire logic [otc_pkg::PIN_SEL_W-1:0] stamp_pin_sel,
  input wire logic [2*otc_pkg::DATA_W-1:0] free_count,
  input wire logic [otc_pkg::DATA_W-1:0] slot_remaining,
  // Trims and status
  input wire logic [otc_pkg::HF_TRIM_W-1:0] hf_osc_trim,
  input wire logic [otc_pkg::FAST_LF_TRIM_W-1:0] fast_lf_osc_trim,
  input wire logic [otc_pkg::SLOW_TRIM_W-1:0] slow_osc_trim,
  input wire logic hf_cal_trigger,
  input wire logic stamp_arm,
  input wire logic stamp_taken
);
  import otc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic pin;
  logic wr_slow;
  assign pin = gpio_in[stamp_pin_sel];
  assign wr_slow = reg_req.wr && (reg_req.addr == ADDR_SLOW_CTRL);
  sequence s_rise;
    stamp_arm && pin && !$past(pin);
  endsequence
  a_read_answer: assert property (reg_req.rd |=> reg_rvalid) else $error("no read answer");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_req.rd)) else $error("stray answer");
  a_hf_trim_write: assert property (reg_req.wr && reg_req.addr == ADDR_HF_TRIM
    |=> hf_osc_trim == $past(reg_req.wdata[7:0])) else $error("fast trim not written");
  a_hf_trim_hold: assert property (!reg_req.wr |=> $stable(hf_osc_trim))
    else $error("fast trim moved");
  a_lf_trim_write: assert property (reg_req.wr && reg_req.addr == ADDR_FAST_LF_TRIM
    |=> fast_lf_osc_trim == $past(reg_req.wdata[9:0])) else $error("1 MHz trim not written");
  a_slow_ctrl_write: assert property (wr_slow
    |=> slow_osc_trim == $past(reg_req.wdata[5:0]) && stamp_arm == $past(reg_req.wdata[15]))
    else $error("slow control not written");
  a_cal_start: assert property (reg_req.wr && reg_req.addr == ADDR_HF_CAL
    && reg_req.wdata[15] && !hf_cal_trigger |=> hf_cal_trigger) else $error("no cal start");
  a_cal_done: assert property ($fell(hf_cal_trigger) |-> $past(lf_osc_tick, 2))
    else $error("cal ended off tick");
  a_stamp_capture: assert property (s_rise |-> ##2 stamp_taken)
    else $error("no capture");
  a_arm_clears: assert property (s_rise ##1 !wr_slow |=> !stamp_arm)
    else $error("arm not cleared");
endmodule // otc_monitor

// ---- otc_osc_model.sv ----
`timescale 1ns/1ns
module otc_osc_model #(
  parameter int LF_DIV = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Ticks
  output logic hf_osc_tick,
  output logic lf_osc_tick
);
  int phase;
  always_ff @(posedge core_clk) begin
    phase <= rst ? 0 : (phase + 1) % LF_DIV;
  end
  assign lf_osc_tick = (phase == 0);
  // One fast tick missing per slow period, so counting cycles is caught
  assign hf_osc_tick = (phase != 1);
endmodule // otc_osc_model

// ---- otc_tb.sv ----
`timescale 1ns/1ns
module testbench;
  import otc_pkg::*;
  logic core_clk, rst, reg_rvalid, hf_osc_tick, lf_osc_tick, lf_slow_sel;
  logic hf_cal_trigger, stamp_arm, stamp_taken;
  otc_reg_req_t reg_req;
  logic [DATA_W-1:0] reg_rdata, slot_remaining;
  logic [GPIO_W-1:0] gpio_in;
  logic [PIN_SEL_W-1:0] stamp_pin_sel;
  logic [2*DATA_W-1:0] free_count;
  logic [HF_TRIM_W-1:0] hf_osc_trim;
  logic [FAST_LF_TRIM_W-1:0] fast_lf_osc_trim;
  logic [SLOW_TRIM_W-1:0] slow_osc_trim;
  int errors, tests_run;
  otc_osc_model #(.LF_DIV(4)) u_osc (.core_clk, .rst, .hf_osc_tick, .lf_osc_tick);
  otc_top dut (.core_clk, .rst, .reg_req, .reg_rdata, .reg_rvalid, .hf_osc_tick,
    .lf_osc_tick, .lf_slow_sel, .gpio_in, .stamp_pin_sel, .free_count, .slot_remaining,
    .hf_osc_trim, .fast_lf_osc_trim, .slow_osc_trim, .hf_cal_trigger, .stamp_arm, .stamp_taken);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task stop_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task step;
    @(posedge core_clk);
    #1;
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_req = '{1'b1, 1'b0, a, d};
    step;
    reg_req.wr = 1'b0;
    step;
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    step;
    reg_req.rd = 1'b0;
    chk({15'h0000, reg_rvalid}, 16'h0001, "read answer");
    chk(reg_rdata, exp, "read data");
    step;
  endtask
  task t_reset;
    rd(ADDR_HF_TRIM, 16'h0090);
    rd(ADDR_HF_CAL, 16'h0000);
    rd(ADDR_FAST_LF_TRIM, 16'h02B2);
    rd(ADDR_SLOW_CTRL, 16'h0012);
    rd(ADDR_STAMP_LOW, 16'h0000);
    rd(ADDR_STAMP_HIGH, 16'h0000);
    rd(ADDR_STAMP_SLOT, 16'h0000);
    rd(16'h0010, 16'h0000);
  endtask
  task t_trims;
    wr(ADDR_HF_TRIM, 16'hFFFF);
    rd(ADDR_HF_TRIM, 16'h00FF);
    chk({8'h00, hf_osc_trim}, 16'h00FF, "fast trim pins");
    wr(ADDR_FAST_LF_TRIM, 16'hFFFF);
    rd(ADDR_FAST_LF_TRIM, 16'h03FF);
    chk({6'h00, fast_lf_osc_trim}, 16'h03FF, "1 MHz trim pins");
    wr(ADDR_SLOW_CTRL, 16'h7FFF);
    rd(ADDR_SLOW_CTRL, 16'h003F);
    chk({10'h000, slow_osc_trim}, 16'h003F, "slow trim pins");
    wr(ADDR_STAMP_HIGH, 16'hFFFF);
    rd(ADDR_STAMP_HIGH, 16'h0000);
    wr(ADDR_SLOW_CTRL, 16'h0000);
    rd(ADDR_SLOW_CTRL, 16'h0000);
  endtask
  // Model gives three fast ticks per four-cycle slow period
  task t_cal(input logic slow, input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] exp);
    lf_slow_sel = slow;
    wr(ADDR_HF_CAL, 16'h8000);
    chk({15'h0000, hf_cal_trigger}, 16'h0001, "cal busy");
    rd(ADDR_HF_CAL, 16'h8000 | old);
    for (int i = 0; i < 2000 && hf_cal_trigger !== 1'b0; i++) step;
    rd(ADDR_HF_CAL, exp);
  endtask
  task t_stamp(input logic [1:0] sel, input logic [31:0] cnt, input logic [15:0] old);
    stamp_pin_sel = sel;
    free_count = cnt;
    slot_remaining = cnt[23:8];
    gpio_in[sel] = 1'b1;
    step;
    gpio_in[sel] = 1'b0;
    rd(ADDR_STAMP_LOW, old);
    wr(ADDR_SLOW_CTRL, 16'h8012);
    chk({15'h0000, stamp_arm}, 16'h0001, "armed");
    gpio_in[sel] = 1'b1;
    step;
    free_count = ~cnt;
    slot_remaining = 16'h0000;
    for (int i = 0; i < 6 && stamp_taken !== 1'b1; i++) step;
    chk({15'h0000, stamp_taken}, 16'h0001, "stamp taken");
    chk({15'h0000, stamp_arm}, 16'h0000, "arm left set");
    gpio_in[sel] = 1'b0;
    rd(ADDR_STAMP_LOW, cnt[15:0]);
    rd(ADDR_STAMP_HIGH, cnt[31:16]);
    rd(ADDR_STAMP_SLOT, cnt[23:8]);
  endtask
  initial begin
    #2000000;
    errors++;
    stop_test;
  end
  initial begin
    rst = 1'b1;
    reg_req = '0;
    lf_slow_sel = 1'b0;
    gpio_in = '0;
    stamp_pin_sel = '0;
    free_count = '0;
    slot_remaining = '0;
    errors = 0;
    tests_run = 0;
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    t_reset;
    t_trims;
    t_cal(1'b0, 16'h0000, 16'h0180);
    t_cal(1'b1, 16'h0180, 16'h0060);
    t_stamp(2'h0, 32'hA5C3_1E7F, 16'h0000);
    t_stamp(2'h2, 32'h5A3C_E180, 16'h1E7F);
    stop_test;
  end
endmodule // testbench
bind otc_top otc_monitor u_mon (.core_clk, .rst, .reg_req, .reg_rdata, .reg_rvalid,
  .hf_osc_tick, .lf_osc_tick, .lf_slow_sel, .gpio_in, .stamp_pin_sel, .free_count,
  .slot_remaining, .hf_osc_trim, .fast_lf_osc_trim, .slow_osc_trim, .hf_cal_trigger,
  .stamp_arm, .stamp_taken);
